//--- src/mcd_defines.vh
// Purpose: shared constants for the instruction decoder core
// Assumes: 12-bit words; decoder bit 0 is the word's least significant bit
// Notes:   printed bit n of a word is Verilog bit 11-n
`ifndef MCD_DEFINES_VH
`define MCD_DEFINES_VH

// Major opcodes, word bits 11:9
`define MCD_OP_AND     3'h0
`define MCD_OP_TAD     3'h1
`define MCD_OP_ISZ     3'h2
`define MCD_OP_DCA     3'h3
`define MCD_OP_JMS     3'h4
`define MCD_OP_JMP     3'h5
`define MCD_OP_IOT     3'h6
`define MCD_OP_OPR     3'h7

// Memory reference fields
`define MCD_B_IND      8
`define MCD_B_PAGE     7

// Group one bits
`define MCD_B_GRP      8
`define MCD_B_CLA      7
`define MCD_B_CLL      6
`define MCD_B_CMA      5
`define MCD_B_CML      4
`define MCD_B_RAR      3
`define MCD_B_RAL      2
`define MCD_B_TWICE    1
`define MCD_B_IAC      0

// Group two bits
`define MCD_B_SMA      6
`define MCD_B_SZA      5
`define MCD_B_SNL      4
`define MCD_B_REV      3
`define MCD_B_OSR      2
`define MCD_B_HLT      1
`define MCD_B_G3       0

// Fixed interrupt, power low skip and tick clock words (octal 6001..6006)
`define MCD_W_IRQ_ON   12'hc01
`define MCD_W_IRQ_OFF  12'hc02
`define MCD_W_PWR_SKIP 12'hc03
`define MCD_W_TICK_ON  12'hc04
`define MCD_W_TICK_OFF 12'hc05
`define MCD_W_TICK_SKP 12'hc06

// Register map, byte addresses
`define MCD_A_CTRL     8'h00
`define MCD_A_SWITCH   8'h04
`define MCD_A_STATUS   8'h08
`define MCD_A_PC       8'h0c
`define MCD_CTRL_START 0

// Reset values and bus answers
`define MCD_PC_RST     12'h000
`define MCD_SW_RST     12'h000
`define MCD_RESP_OKAY  2'h0
`define MCD_RESP_SLV   2'h2

`endif

//--- src/mcd_operate.v
// Purpose: combinational group one and group two operate unit
// Assumes: word is an operate word; caller commits results
// Notes:   group three words (bit 0 set in group two) pass unchanged
`timescale 1ns/1ps
`include "mcd_defines.vh"

module mcd_operate (
  input  wire [11:0] instr,     // operate word
  input  wire [11:0] acc,       // accumulator now
  input  wire        link,      // link now
  input  wire [11:0] switches,  // front panel switch register
  output reg  [11:0] nextAcc,   // accumulator after the word
  output reg         nextLink,  // link after the word
  output reg         skip,      // skip the next word
  output reg         halt       // stop after this word
);

  reg [12:0] lv;
  reg [12:0] inc;
  reg        allTrue;
  reg        anyTrue;

  // One place of rotation through the 13-bit link and accumulator
  function [12:0] rotOnce(input [12:0] v, input left);
    begin
      rotOnce = left ? {v[11:0], v[12]} : {v[0], v[12:1]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Operate evaluation
  always @* begin
    lv       = {link, acc};
    inc      = 13'h0000;
    allTrue  = 1'b0;
    anyTrue  = 1'b0;
    nextAcc  = acc;
    nextLink = link;
    skip     = 1'b0;
    halt     = 1'b0;
    if (!instr[`MCD_B_GRP]) begin
      if (instr[`MCD_B_CLA])
        lv[11:0] = 12'h000;
      if (instr[`MCD_B_CLL])
        lv[12] = 1'b0;
      if (instr[`MCD_B_CMA])
        lv[11:0] = ~lv[11:0];
      if (instr[`MCD_B_CML])
        lv[12] = ~lv[12];
      if (instr[`MCD_B_IAC]) begin
        inc = {1'b0, lv[11:0]} + 13'h0001;
        lv  = {lv[12] ^ inc[12], inc[11:0]};
      end
      if (instr[`MCD_B_RAR]) begin
        lv = rotOnce(lv, 1'b0);
        if (instr[`MCD_B_TWICE])
          lv = rotOnce(lv, 1'b0);
      end else if (instr[`MCD_B_RAL]) begin
        lv = rotOnce(lv, 1'b1);
        if (instr[`MCD_B_TWICE])
          lv = rotOnce(lv, 1'b1);
      end
      nextAcc  = lv[11:0];
      nextLink = lv[12];
    end else if (!instr[`MCD_B_G3]) begin
      anyTrue = (instr[`MCD_B_SMA] & acc[11])
              | (instr[`MCD_B_SZA] & (acc == 12'h000))
              | (instr[`MCD_B_SNL] & link);
      // all-true group, empty set always skips
      allTrue = (~instr[`MCD_B_SMA] | ~acc[11])
              & (~instr[`MCD_B_SZA] | (acc != 12'h000))
              & (~instr[`MCD_B_SNL] | ~link);
      skip = instr[`MCD_B_REV] ? allTrue : anyTrue;
      if (instr[`MCD_B_CLA])
        nextAcc = 12'h000;
      if (instr[`MCD_B_OSR])
        nextAcc = nextAcc | switches;
      halt = instr[`MCD_B_HLT];
    end
  end

endmodule

//--- src/mcd_decoder.v
// Purpose: 12-bit minicomputer instruction decoder and sequencer
// Assumes: core memory answers one read or write per memAck pulse
// Notes:   registers on AXI4-Lite; peripherals on a strobed I/O port
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "mcd_defines.vh"

module mcd_decoder (
  input  wire        clock,         // 250 MHz core clock
  input  wire        rst,           // async reset, active high
  input  wire [7:0]  awaddr,        // write address
  input  wire        awvalid,       // write address valid
  output reg         awready,       // write address ready
  input  wire [31:0] wdata,         // write data
  input  wire [3:0]  wstrb,         // write byte lanes
  input  wire        wvalid,        // write data valid
  output reg         wready,        // write data ready
  output reg  [1:0]  bresp,         // write response
  output reg         bvalid,        // write response valid
  input  wire        bready,        // write response ready
  input  wire [7:0]  araddr,        // read address
  input  wire        arvalid,       // read address valid
  output reg         arready,       // read address ready
  output reg  [31:0] rdata,         // read data
  output reg  [1:0]  rresp,         // read response
  output reg         rvalid,        // read data valid
  input  wire        rready,        // read data ready
  output reg         memReq,        // memory cycle request
  output reg         memWe,         // cycle is a write
  output reg  [11:0] memAddr,       // memory word address
  output reg  [11:0] memWdata,      // word to store
  input  wire [11:0] memRdata,      // word read, valid with memAck
  input  wire        memAck,        // one-cycle completion pulse
  output reg         ioStrobe,      // one-cycle I/O transfer pulse
  output reg  [5:0]  ioDevice,      // addressed peripheral
  output reg  [2:0]  ioFunc,        // function code
  output reg  [11:0] ioAcOut,       // accumulator offered to device
  input  wire        ioSkip,        // device asks for a skip
  input  wire        powerLow,      // power low pin, asynchronous
  input  wire        tickDone,      // line clock done pin, asynchronous
  output reg         irqEnable,     // interrupt system enabled
  output reg         tickClockRun,  // line clock running
  output reg         running        // processor fetching
);

  localparam S_HALT   = 3'h0;
  localparam S_FETCH  = 3'h1;
  localparam S_DECODE = 3'h2;
  localparam S_DEFER  = 3'h3;
  localparam S_EXEC   = 3'h4;
  localparam S_OPER   = 3'h5;
  localparam S_STORE  = 3'h6;
  localparam S_IO     = 3'h7;

  reg  [2:0]  state;
  reg  [11:0] pc;
  reg  [11:0] acc;
  reg         link;
  reg  [11:0] instr;
  reg  [4:0]  curPage;
  reg  [11:0] eaddr;
  reg  [11:0] switches;
  reg  [7:0]  wAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         startReq;
  reg         pcWrReq;
  reg  [11:0] pcWrVal;
  reg         pwrMeta;
  reg         pwrSync;
  reg         tickMeta;
  reg         tickSync;
  wire [11:0] opAcc;
  wire        opLink;
  wire        opSkip;
  wire        opHalt;
  wire [2:0]  opcode;
  wire [11:0] eaDirect;
  wire [12:0] tadSum;
  wire [11:0] iszSum;
  wire [11:0] pcPlusOne;
  wire        memState;
  wire        memDone;

  // Byte-lane merge of a 12-bit register; lanes above 1 hold nothing
  function [11:0] laneMerge(input [11:0] old, input [31:0] data, input [3:0] strb);
    begin
      laneMerge = {strb[1] ? data[11:8] : old[11:8],
                   strb[0] ? data[7:0]  : old[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Operate unit
  mcd_operate u_operate (
    .instr    (instr),
    .acc      (acc),
    .link     (link),
    .switches (switches),
    .nextAcc  (opAcc),
    .nextLink (opLink),
    .skip     (opSkip),
    .halt     (opHalt)
  );

  // Address and arithmetic helpers
  assign opcode    = instr[11:9];
  assign eaDirect  = instr[`MCD_B_PAGE] ? {curPage, instr[6:0]} : {5'h00, instr[6:0]};
  assign tadSum    = {1'b0, acc} + {1'b0, memRdata};
  assign iszSum    = memRdata + 12'h001;
  assign pcPlusOne = pc + 12'h001;
  assign memState  = (state == S_FETCH) || (state == S_DEFER) ||
                     (state == S_OPER) || (state == S_STORE);
  assign memDone   = memReq && memAck;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers; the meta stages feed only the second stage
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pwrMeta  <= 1'b0;
      pwrSync  <= 1'b0;
      tickMeta <= 1'b0;
      tickSync <= 1'b0;
    end else begin
      pwrMeta  <= powerLow;
      pwrSync  <= pwrMeta;
      tickMeta <= tickDone;
      tickSync <= tickMeta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus write side: address and data taken in either order
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= `MCD_RESP_OKAY;
      wAddr    <= 8'h00;
      wData    <= 32'h00000000;
      wStrb    <= 4'h0;
      switches <= `MCD_SW_RST;
      startReq <= 1'b0;
      pcWrReq  <= 1'b0;
      pcWrVal  <= `MCD_PC_RST;
    end else begin
      startReq <= 1'b0;
      pcWrReq  <= 1'b0;
      if (awvalid && awready) begin
        wAddr   <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wData  <= wdata;
        wStrb  <= wstrb;
        wready <= 1'b0;
      end
      // Both halves held: commit once, then answer
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        bresp  <= `MCD_RESP_OKAY;
        if (wAddr == `MCD_A_CTRL) begin
          startReq <= wStrb[0] & wData[`MCD_CTRL_START];
        end else if (wAddr == `MCD_A_SWITCH) begin
          switches <= laneMerge(switches, wData, wStrb);
        end else if (wAddr == `MCD_A_PC) begin
          pcWrReq <= 1'b1;
          pcWrVal <= laneMerge(pc, wData, wStrb);
        end else if (wAddr != `MCD_A_STATUS) begin
          bresp <= `MCD_RESP_SLV;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus read side: answer one cycle after the address is taken
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rresp   <= `MCD_RESP_OKAY;
      rdata   <= 32'h00000000;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `MCD_RESP_OKAY;
        if (araddr == `MCD_A_CTRL) begin
          rdata <= {31'h00000000, running};
        end else if (araddr == `MCD_A_SWITCH) begin
          rdata <= {20'h00000, switches};
        end else if (araddr == `MCD_A_STATUS) begin
          rdata <= {14'h0000, tickSync, pwrSync, running, tickClockRun,
                    irqEnable, link, acc};
        end else if (araddr == `MCD_A_PC) begin
          rdata <= {20'h00000, pc};
        end else begin
          rdata <= 32'h00000000;
          rresp <= `MCD_RESP_SLV;
        end
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer: fetch, defer, execute, operand and store cycles
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state        <= S_HALT;
      pc           <= `MCD_PC_RST;
      acc          <= 12'h000;
      link         <= 1'b0;
      instr        <= 12'h000;
      curPage      <= 5'h00;
      eaddr        <= 12'h000;
      memReq       <= 1'b0;
      memWe        <= 1'b0;
      memAddr      <= 12'h000;
      memWdata     <= 12'h000;
      ioStrobe     <= 1'b0;
      ioDevice     <= 6'h00;
      ioFunc       <= 3'h0;
      ioAcOut      <= 12'h000;
      irqEnable    <= 1'b0;
      tickClockRun <= 1'b0;
      running      <= 1'b0;
    end else begin
      ioStrobe <= 1'b0;
      // A memory state raises its request on its first cycle
      if (memState && !memReq) begin
        memReq  <= 1'b1;
        memAddr <= (state == S_FETCH) ? pc : eaddr;
        memWe   <= (state == S_STORE);
      end
      case (state)
        S_HALT: begin
          // PC loads only while stopped, so software cannot race the fetch
          if (pcWrReq)
            pc <= pcWrVal;
          if (startReq) begin
            running <= 1'b1;
            state   <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (memDone) begin
            memReq  <= 1'b0;
            instr   <= memRdata;
            curPage <= pc[11:7];
            pc      <= pcPlusOne;
            state   <= S_DECODE;
          end
        end
        S_DECODE: begin
          eaddr <= eaDirect;
          if ((opcode < `MCD_OP_IOT) && instr[`MCD_B_IND])
            state <= S_DEFER;
          else
            state <= S_EXEC;
        end
        S_DEFER: begin
          if (memDone) begin
            memReq <= 1'b0;
            eaddr  <= memRdata;
            state  <= S_EXEC;
          end
        end
        S_EXEC: begin
          state <= S_FETCH;
          case (opcode)
            `MCD_OP_AND, `MCD_OP_TAD, `MCD_OP_ISZ: begin
              state <= S_OPER;
            end
            `MCD_OP_DCA: begin
              memWdata <= acc;
              acc      <= 12'h000;
              state    <= S_STORE;
            end
            `MCD_OP_JMS: begin
              memWdata <= pc;
              pc       <= eaddr + 12'h001;
              state    <= S_STORE;
            end
            `MCD_OP_JMP: begin
              pc <= eaddr;
            end
            `MCD_OP_IOT: begin
              if (instr == `MCD_W_IRQ_ON) begin
                irqEnable <= 1'b1;
              end else if (instr == `MCD_W_IRQ_OFF) begin
                irqEnable <= 1'b0;
              end else if (instr == `MCD_W_PWR_SKIP) begin
                if (pwrSync)
                  pc <= pcPlusOne;
              end else if (instr == `MCD_W_TICK_ON) begin
                tickClockRun <= 1'b1;
              end else if (instr == `MCD_W_TICK_OFF) begin
                tickClockRun <= 1'b0;
              end else if (instr == `MCD_W_TICK_SKP) begin
                if (tickSync)
                  pc <= pcPlusOne;
              end else begin
                ioStrobe <= 1'b1;
                ioDevice <= instr[8:3];
                ioFunc   <= instr[2:0];
                ioAcOut  <= acc;
                state    <= S_IO;
              end
            end
            default: begin
              acc  <= opAcc;
              link <= opLink;
              if (opSkip)
                pc <= pcPlusOne;
              if (opHalt) begin
                running <= 1'b0;
                state   <= S_HALT;
              end
            end
          endcase
        end
        S_OPER: begin
          if (memDone) begin
            memReq <= 1'b0;
            state  <= S_FETCH;
            if (opcode == `MCD_OP_AND) begin
              acc <= acc & memRdata;
            end else if (opcode == `MCD_OP_TAD) begin
              acc <= tadSum[11:0];
              // Carry complements the link, as with increment
              if (tadSum[12])
                link <= ~link;
            end else begin
              memWdata <= iszSum;
              if (iszSum == 12'h000)
                pc <= pcPlusOne;
              state <= S_STORE;
            end
          end
        end
        S_STORE: begin
          if (memDone) begin
            memReq <= 1'b0;
            state  <= S_FETCH;
          end
        end
        default: begin
          // Device answers while the strobe stands
          if (ioSkip)
            pc <= pcPlusOne;
          state <= S_FETCH;
        end
      endcase
    end
  end

endmodule

//--- testbench/mcd_decoder_sva.sv
// Purpose: port checks for the decoder core
// Assumes: one clock, async active high reset
// Notes:   lastWord holds the newest word read from memory
`timescale 1ns/1ps

module mcd_decoder_sva (
  input wire        clock,         // clock
  input wire        rst,           // reset
  input wire        awvalid,       // aw valid
  input wire        awready,       // aw ready
  input wire        wvalid,        // w valid
  input wire        wready,        // w ready
  input wire [1:0]  bresp,         // b resp
  input wire        bvalid,        // b valid
  input wire        bready,        // b ready
  input wire [7:0]  araddr,        // ar addr
  input wire        arvalid,       // ar valid
  input wire        arready,       // ar ready
  input wire [31:0] rdata,         // r data
  input wire [1:0]  rresp,         // r resp
  input wire        rvalid,        // r valid
  input wire        rready,        // r ready
  input wire        memReq,        // mem request
  input wire        memWe,         // mem write
  input wire [11:0] memAddr,       // mem address
  input wire [11:0] memRdata,      // mem word in
  input wire        memAck,        // mem done
  input wire        ioStrobe,      // io pulse
  input wire [5:0]  ioDevice,      // io device
  input wire [2:0]  ioFunc,        // io function
  input wire        irqEnable,     // irq on
  input wire        tickClockRun,  // tick on
  input wire        running        // fetching
);
  reg  [11:0] lastWord;
  wire        wordIn = memReq && memAck && !memWe;

  // I/O words need no operand, so this is the I/O word at strobe time
  always @(posedge clock or posedge rst) begin
    if (rst) lastWord <= 12'h000;
    else if (wordIn) lastWord <= memRdata;
  end

  //////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wr_both; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd_bad; arvalid && arready && !(araddr inside {8'h00, 8'h04, 8'h08, 8'h0c});
  endsequence
  sequence s_word(w); memReq && memAck && !memWe && memRdata == w; endsequence
  property p_wr_answer; s_wr_both |-> ##[1:3] bvalid; endproperty
  property p_rd_answer; arvalid && arready |-> ##[1:2] rvalid; endproperty
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_unmapped; s_rd_bad |-> ##[1:2] (rvalid && rresp == 2'h2); endproperty
  property p_mem_hold; memReq && !memAck |=> memReq && $stable(memAddr); endproperty
  property p_mem_drop; memReq && memAck |=> !memReq; endproperty
  property p_io_pulse; ioStrobe |=> !ioStrobe; endproperty
  property p_io_fields; ioStrobe |-> ioDevice == lastWord[8:3] && ioFunc == lastWord[2:0];
  endproperty
  property p_halt; !running |-> !$rose(memReq); endproperty
  property p_irq_on; s_word(12'hc01) |-> ##[1:8] irqEnable; endproperty
  property p_tick_on; s_word(12'hc04) |-> ##[1:8] tickClockRun; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_mem_hold: assert property (p_mem_hold) else $error("memory request not held");
  a_mem_drop: assert property (p_mem_drop) else $error("memory request kept after ack");
  a_io_pulse: assert property (p_io_pulse) else $error("io strobe too long");
  a_io_fields: assert property (p_io_fields) else $error("io fields wrong");
  a_halt: assert property (p_halt) else $error("fetch while stopped");
  a_irq_on: assert property (p_irq_on) else $error("irq enable word ignored");
  a_tick_on: assert property (p_tick_on) else $error("tick on word ignored");
endmodule

bind mcd_decoder mcd_decoder_sva u_sva (
  .clock(clock), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
  .memRdata(memRdata), .memAck(memAck), .ioStrobe(ioStrobe), .ioDevice(ioDevice),
  .ioFunc(ioFunc), .irqEnable(irqEnable), .tickClockRun(tickClockRun), .running(running)
);

//--- testbench/mcd_mem_model.sv
// Purpose: core memory and one peripheral beside the decoder
// Assumes: one request at a time, answered after delay idle cycles
// Notes:   data lines flip every cycle between answers, last word and its inverse in turn
`timescale 1ns/1ps

module mcd_mem_model (
  input  wire        clock,     // clock
  input  wire        rst,       // reset
  input  wire        memReq,    // request
  input  wire        memWe,     // write cycle
  input  wire [11:0] memAddr,   // address
  input  wire [11:0] memWdata,  // word to store
  output reg  [11:0] memRdata,  // word read
  output reg         memAck,    // done pulse
  input  wire        ioStrobe,  // io pulse
  input  wire [2:0]  ioFunc,    // io function
  output wire        ioSkip,    // device skip
  input  wire [3:0]  delay      // wait cycles
);
  reg [11:0] store [0:4095];
  reg [3:0]  waitCnt;

  // Device always ready: function one asks for a skip
  assign ioSkip = ioStrobe && ioFunc == 3'h1;

  //////////////////////////////
  // One answer per request; stale data never looks valid
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      memAck   <= 1'b0;
      waitCnt  <= 4'h0;
      memRdata <= 12'h000;
    end else begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck && waitCnt >= delay) begin
        memAck  <= 1'b1;
        waitCnt <= 4'h0;
        if (memWe) store[memAddr] <= memWdata;
        else memRdata <= store[memAddr];
      end else if (memReq && !memAck) begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule

//--- testbench/tb.sv
// Purpose: self-checking bench for the decoder core
// Assumes: program placed in the memory model before start
// Notes:   each halt is a checkpoint read through STATUS
`timescale 1ns/1ps
`include "mcd_defines.vh"

module tb;
  reg         clock = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0, powerLow = 1'b0, tickDone = 1'b0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg  [3:0]  wstrb = 4'hf, delay = 4'h0;
  wire        awready, wready, bvalid, arready, rvalid, memReq, memWe, memAck;
  wire        ioStrobe, ioSkip, irqEnable, tickClockRun, running;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] memAddr, memWdata, memRdata, ioAcOut;
  wire [5:0]  ioDevice;
  wire [2:0]  ioFunc;
  integer     n_mismatch = 0, comparisons = 0;
  reg  [11:0] prog [0:34] = '{12'hea0, 12'he01, 12'hf02, 12'he08, 12'hf02, 12'he04,
    12'hf02, 12'hed6, 12'hf02, 12'hf86, 12'hf40, 12'he01, 12'hf48, 12'he01, 12'hf60,
    12'he01, 12'hf68, 12'he01, 12'hf58, 12'he01, 12'hf50, 12'he01, 12'hf08, 12'he01,
    12'hf02, 12'hca9, 12'he01, 12'hc01, 12'hc04, 12'hf02, 12'h2f0, 12'h210, 12'h311,
    12'h6f2, 12'hae0};
  reg  [15:0] expSt [0:7] = '{16'h1000, 16'h0800, 16'h1000, 16'h0002, 16'h00a5,
    16'h00a8, 16'h60a8, 16'h6000};

  mcd_decoder dut (
    .clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .ioStrobe(ioStrobe), .ioDevice(ioDevice),
    .ioFunc(ioFunc), .ioAcOut(ioAcOut), .ioSkip(ioSkip), .powerLow(powerLow),
    .tickDone(tickDone), .irqEnable(irqEnable), .tickClockRun(tickClockRun),
    .running(running));
  mcd_mem_model mem (
    .clock(clock), .rst(rst), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .ioStrobe(ioStrobe),
    .ioFunc(ioFunc), .ioSkip(ioSkip), .delay(delay));

  // 250 MHz
  always #2 clock = ~clock;

  //////////////////////////////
  task chk(input [31:0] got, input [31:0] exp, input string what);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
      end
    end
  endtask

  // Both channels offered together, each dropped once taken
  task axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge clock);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
    end
  endtask

  task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge clock);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
    end
  endtask

  task stop_test;
    begin
      $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask

  //////////////////////////////
  // Reset values, refusals, read-only status, switch register
  task s_regs;
    reg [31:0] d;
    reg [1:0]  r;
    begin
      axi_rd(`MCD_A_STATUS, d, r);
      chk(d, 32'h0, "status reset");
      axi_rd(`MCD_A_SWITCH, d, r);
      chk(d, 32'h0, "switch reset");
      axi_rd(8'h10, d, r);
      chk({d[29:0], r}, 32'h2, "unmapped read");
      axi_wr(8'h10, 32'h5, r);
      chk({30'h0, r}, 32'h2, "unmapped write");
      axi_wr(`MCD_A_STATUS, 32'hfff, r);
      axi_rd(`MCD_A_STATUS, d, r);
      chk(d, 32'h0, "status read only");
      powerLow <= 1'b1;
      repeat (3) @(posedge clock);
      axi_rd(`MCD_A_STATUS, d, r);
      chk(d, 32'h10000, "power low pin");
      powerLow <= 1'b0;
      axi_wr(`MCD_A_SWITCH, 32'hfff0a5, r);
      axi_rd(`MCD_A_SWITCH, d, r);
      chk(d, 32'h0a5, "switch");
    end
  endtask

  // Program run in halt-separated steps, memory speed varied per step
  task s_program;
    reg [31:0] d;
    reg [1:0]  r;
    integer    i, k;
    begin
      for (i = 0; i < 35; i = i + 1) mem.store[12'h080 + i] = prog[i];
      mem.store[12'h0e0] = 12'hf02;
      mem.store[12'h0f0] = 12'h005;
      mem.store[12'h010] = 12'h100;
      mem.store[12'h011] = 12'h0f1;
      mem.store[12'h0f1] = 12'h020;
      axi_wr(`MCD_A_PC, 32'h080, r);
      for (i = 0; i < 8; i = i + 1) begin
        delay <= {2'b00, i[1:0]};
        axi_wr(`MCD_A_CTRL, 32'h1, r);
        k = 0;
        while (!running && k < 50) begin
          @(posedge clock);
          k = k + 1;
        end
        chk({31'h0, running}, 32'h1, "start");
        while (running && k < 5000) begin
          @(posedge clock);
          k = k + 1;
        end
        axi_rd(`MCD_A_STATUS, d, r);
        chk(d & 32'h3ffff, {16'h0, expSt[i]}, "checkpoint");
      end
      axi_rd(`MCD_A_PC, d, r);
      chk(d, 32'h0e1, "pc after stop");
      chk({20'h0, mem.store[12'h0f2]}, 32'h1cd, "deposit");
      chk({11'h0, ioDevice, ioFunc, ioAcOut}, {11'h0, 6'h15, 3'h1, 12'h0a8}, "io");
    end
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    s_regs;
    s_program;
    stop_test;
  end

  // Far beyond the expected run time, so only a hang gets here
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
endmodule
